// >>> verilog/ppc_regs.v
// Purpose: Power, test and configuration register bank on classic Wishbone
// Assumes: 32-bit bus, registers in low 16 bits, one wait state per access
// Notes:   Exit timer lengths are parameters to shorten simulation
//
// How it works
// - Analog supply force bit makes supply read as 3.3 V, else detector decides.
// - I/O supply force 11 means 3.3 V; 00 leaves detection to circuit.
// - Test pattern sends one then N zeros; N zero clears shift register.
// - Idle test mode bit selects test pattern, otherwise normal transmit.
// - Deep power-down exit takes 50 ms when speed bit set, else 100 ms.
// - Deep power-down enable bit puts the device into deep power-down while standard power-down is active.
// - Calibration bypass bit skips equalizer calibration.
// - Minimum gap is 120 ns with gap bit set, else 0.20 us.
`timescale 1ns/1ps
`include "ppc_map.vh"
module ppc_regs #(
	parameter [23:0] EXIT_FAST_CYC = `PPC_EXIT_FAST_CYC,
	parameter [23:0] EXIT_SLOW_CYC = `PPC_EXIT_SLOW_CYC
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        ce_i,
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [15:0] adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	output reg         err_o,
	input  wire        ana_det_i,
	input  wire [1:0]  io_det_i,
	input  wire        std_pwdn_i,
	input  wire [3:0]  idle_low_i,
	output reg         ana_3v3_o,
	output reg  [1:0]  io_level_o,
	output reg         deep_pwdn_o,
	output reg         pwdn_exiting_o,
	output reg         idle_test_o,
	output reg         idle_bit_o,
	output reg         eq_cal_bypass_o,
	output reg  [3:0]  ipg_cycles_o
);
	// ****************************************
	// Storage
	// ****************************************
	reg  [15:0] aeq_q;
	reg  [15:0] supply_q;
	reg  [15:0] dpd_q;
	reg  [15:0] dsp6_q;
	reg  [15:0] gen_q;
	reg  [15:0] rd_d;
	reg         hit_d;
	wire [11:0] idx;
	wire        req;
	wire        deep_w;
	wire        exit_w;
	wire        idle_w;
	// Full-width gap counts; only the low nibble reaches the port
	localparam [31:0] IPG_MIN_FULL = `PPC_IPG_MIN_CYC;
	localparam [31:0] IPG_STD_FULL = `PPC_IPG_STD_CYC;

	assign idx = adr_i[13:2];
	assign req = cyc_i && stb_i && !ack_o && !err_o;

	// Byte-lane merge used by every writable register
	function [15:0] merge;
		input [15:0] old;
		input [31:0] wd;
		input [3:0]  sel;
		begin
			merge = old;
			if (sel[0])
				merge[7:0] = wd[7:0];
			if (sel[1])
				merge[15:8] = wd[15:8];
		end
	endfunction

	// ****************************************
	// Read decode
	// ****************************************
	always @* begin
		hit_d = 1'b1;
		rd_d  = 16'h0000;
		case (idx)
			`PPC_IDX_AEQ:    rd_d = aeq_q;
			`PPC_IDX_SUPPLY: rd_d = supply_q;
			`PPC_IDX_LEVEL:  rd_d = {13'h0, ana_3v3_o, io_level_o};
			`PPC_IDX_DPD:    rd_d = dpd_q & `PPC_WM_DPD;
			`PPC_IDX_DSP6:   rd_d = dsp6_q;
			`PPC_IDX_GEN:    rd_d = gen_q;
			`PPC_IDX_STAT:   rd_d = {12'h000, std_pwdn_i, pwdn_exiting_o, deep_pwdn_o,
				idle_test_o};
			default:         hit_d = 1'b0;
		endcase
		if (adr_i[15:14] != 2'b00)
			hit_d = 1'b0;
	end

	// ****************************************
	// Bus slave and register writes
	// ****************************************
	always @(posedge clk_i) begin
		if (rst_i) begin
			aeq_q    <= `PPC_RST_AEQ;
			supply_q <= `PPC_RST_SUPPLY;
			dpd_q    <= `PPC_RST_DPD;
			dsp6_q   <= `PPC_RST_DSP6;
			gen_q    <= `PPC_RST_GEN;
			dat_o    <= 32'h00000000;
			ack_o    <= 1'b0;
			err_o    <= 1'b0;
		end else if (ce_i) begin
			ack_o <= req && hit_d;
			err_o <= req && !hit_d;
			dat_o <= 32'h00000000;
			if (req && hit_d && !we_i)
				dat_o <= {16'h0000, rd_d};
			if (req && hit_d && we_i) begin
				case (idx)
					`PPC_IDX_AEQ:    aeq_q <= merge(aeq_q, dat_i, sel_i);
					`PPC_IDX_SUPPLY: supply_q <= merge(supply_q, dat_i, sel_i);
					`PPC_IDX_DPD: begin
						// Enable honoured only with standard power-down active
						dpd_q <= merge(dpd_q, dat_i, sel_i) & `PPC_WM_DPD;
					end
					`PPC_IDX_DSP6:   dsp6_q <= merge(dsp6_q, dat_i, sel_i);
					`PPC_IDX_GEN:    gen_q <= merge(gen_q, dat_i, sel_i);
					default:         dsp6_q <= dsp6_q;
				endcase
			end
		end
	end

	// ****************************************
	// Derived outputs
	// ****************************************
	always @(posedge clk_i) begin
		if (rst_i) begin
			ana_3v3_o       <= 1'b0;
			io_level_o      <= 2'b00;
			idle_test_o     <= 1'b0;
			eq_cal_bypass_o <= 1'b0;
			ipg_cycles_o    <= 4'h0;
			deep_pwdn_o     <= 1'b0;
			pwdn_exiting_o  <= 1'b0;
			idle_bit_o      <= 1'b0;
		end else if (ce_i) begin
			ana_3v3_o <= supply_q[`PPC_SUP_ANA_BIT] ? 1'b1 : ana_det_i;
			// Only 11 forces; other codes fall back to detection
			if (supply_q[`PPC_SUP_IO_HI:`PPC_SUP_IO_LO] == 2'b11)
				io_level_o <= 2'b11;
			else
				io_level_o <= io_det_i;
			idle_test_o     <= dpd_q[`PPC_DPD_TEST_BIT];
			eq_cal_bypass_o <= dsp6_q[`PPC_DSP_BYP_BIT];
			if (gen_q[`PPC_GEN_IPG_BIT])
				ipg_cycles_o <= IPG_MIN_FULL[3:0];
			else
				ipg_cycles_o <= IPG_STD_FULL[3:0];
			deep_pwdn_o    <= deep_w;
			pwdn_exiting_o <= exit_w;
			idle_bit_o     <= idle_w;
		end
	end

	// ****************************************
	// Sub-blocks
	// ****************************************
	ppc_dpd_timer #(
		.FAST_CYC (EXIT_FAST_CYC),
		.SLOW_CYC (EXIT_SLOW_CYC)
	) u_dpd (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.en_i      (dpd_q[`PPC_DPD_EN_BIT] && std_pwdn_i),
		.fast_i    (dpd_q[`PPC_DPD_SPD_BIT]),
		.deep_o    (deep_w),
		.exiting_o (exit_w)
	);

	ppc_idle_gen u_idle (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.en_i    (dpd_q[`PPC_DPD_TEST_BIT]),
		.zeros_i ({dpd_q[`PPC_DPD_MSB_BIT], idle_low_i}),
		.bit_o   (idle_w)
	);
endmodule

// >>> verilog/ppc_map.vh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 25 MHz clock, Wishbone byte addresses = 4 * register index
// Notes:   Definitions only
`ifndef PPC_MAP_VH
`define PPC_MAP_VH

// ****************************************
// Register indices and address width
// ****************************************
`define PPC_IDX_AEQ        12'h418
`define PPC_IDX_SUPPLY     12'h41F
`define PPC_IDX_LEVEL      12'h421
`define PPC_IDX_DPD        12'h428
`define PPC_IDX_DSP6       12'h450
`define PPC_IDX_GEN        12'h456
`define PPC_IDX_STAT       12'h457
`define PPC_ADR_W          14

// ****************************************
// Field positions
// ****************************************
`define PPC_SUP_ANA_BIT    12
`define PPC_SUP_IO_HI      11
`define PPC_SUP_IO_LO      10
`define PPC_DPD_MSB_BIT    5
`define PPC_DPD_TEST_BIT   4
`define PPC_DPD_SPD_BIT    3
`define PPC_DPD_EN_BIT     2
`define PPC_DSP_BYP_BIT    13
`define PPC_GEN_IPG_BIT    3

// ****************************************
// Reset values and write masks
// ****************************************
`define PPC_RST_AEQ        16'h0000
`define PPC_RST_SUPPLY     16'h0000
`define PPC_RST_DPD        16'h0000
`define PPC_RST_DSP6       16'h0141
`define PPC_RST_GEN        16'h0008
`define PPC_WM_DPD         16'h003F

// ****************************************
// Timing
// ****************************************
`define PPC_CLK_HZ         25000000
`define PPC_EXIT_FAST_MS   50
`define PPC_EXIT_SLOW_MS   100
`define PPC_IPG_MIN_NS     120
`define PPC_IPG_STD_NS     200
`define PPC_CLK_NS         40
`define PPC_IPG_MIN_CYC    ((`PPC_IPG_MIN_NS + `PPC_CLK_NS - 1) / `PPC_CLK_NS)
`define PPC_IPG_STD_CYC    ((`PPC_IPG_STD_NS + `PPC_CLK_NS - 1) / `PPC_CLK_NS)
// Exit lengths, 50 ms and 100 ms at 25 MHz, sized for the 24-bit timer
`define PPC_EXIT_FAST_CYC  24'h1312D0
`define PPC_EXIT_SLOW_CYC  24'h2625A0

`endif

// >>> verilog/ppc_idle_gen.v
// Purpose: Idle test pattern: a one followed by N zeros
// Assumes: One symbol per enabled clock
// Notes:   N of zero holds the shift register cleared
`timescale 1ns/1ps
module ppc_idle_gen (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       ce_i,
	input  wire       en_i,
	input  wire [4:0] zeros_i,
	output reg        bit_o
);
	reg [4:0] cnt_q;

	// ****************************************
	// Pattern counter
	// ****************************************
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 5'h00;
			bit_o <= 1'b0;
		end else if (ce_i) begin
			if (!en_i || zeros_i == 5'h00) begin
				cnt_q <= 5'h00;
				bit_o <= 1'b0;
			end else if (cnt_q == 5'h00) begin
				bit_o <= 1'b1;
				cnt_q <= zeros_i;
			end else begin
				bit_o <= 1'b0;
				cnt_q <= cnt_q - 5'h01;
			end
		end
	end
endmodule

// >>> verilog/ppc_dpd_timer.v
// Purpose: Deep power-down state and exit timer
// Assumes: Counts in clock cycles of clk_i
// Notes:   Exit time is sampled when the enable falls
`timescale 1ns/1ps
module ppc_dpd_timer #(
	parameter [23:0] FAST_CYC = 24'd1250000,
	parameter [23:0] SLOW_CYC = 24'd2500000
) (
	input  wire clk_i,
	input  wire rst_i,
	input  wire ce_i,
	input  wire en_i,
	input  wire fast_i,
	output reg  deep_o,
	output reg  exiting_o
);
	reg [23:0] cnt_q;

	// ****************************************
	// Entry and exit
	// ****************************************
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q     <= 24'h000000;
			deep_o    <= 1'b0;
			exiting_o <= 1'b0;
		end else if (ce_i) begin
			if (en_i) begin
				deep_o    <= 1'b1;
				exiting_o <= 1'b0;
				cnt_q     <= 24'h000000;
			end else if (deep_o) begin
				deep_o    <= 1'b0;
				exiting_o <= 1'b1;
				cnt_q     <= (fast_i ? FAST_CYC : SLOW_CYC) - 24'h000001;
			end else if (exiting_o) begin
				if (cnt_q == 24'h000000)
					exiting_o <= 1'b0;
				else
					cnt_q <= cnt_q - 24'h000001;
			end
		end
	end
endmodule

// >>> dv/ppc_regs_properties.sv
// Purpose: Bus and output assertions for ppc_regs
// Assumes: ce_i high around every bus answer
// Notes:   Exit length kept by a counter
`timescale 1ns/1ps
`include "ppc_map.vh"
module ppc_regs_checker #(
	parameter [23:0] EXIT_FAST_CYC = 24'd20,
	parameter [23:0] EXIT_SLOW_CYC = 24'd40
) (
	input logic        clk_i,
	input logic        rst_i,
	input logic        ce_i,
	input logic        cyc_i,
	input logic        stb_i,
	input logic        we_i,
	input logic [15:0] adr_i,
	input logic [31:0] dat_i,
	input logic [31:0] dat_o,
	input logic        ack_o,
	input logic        err_o,
	input logic        std_pwdn_i,
	input logic        deep_pwdn_o,
	input logic        pwdn_exiting_o,
	input logic        idle_test_o,
	input logic        idle_bit_o,
	input logic [3:0]  ipg_cycles_o
);
	logic        take;
	logic [23:0] run_q;
	assign take = ce_i && cyc_i && stb_i && !ack_o && !err_o;
	// Counter, as a repetition cannot reach the exit length
	always @(posedge clk_i)
		run_q <= (rst_i || !pwdn_exiting_o) ? 24'h0 : run_q + {23'h0, ce_i};
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_pulse_a: assert property ((ack_o || err_o) |=> !ack_o && !err_o)
		else $error("answer longer than one cycle");
	ack_cause_a: assert property ($rose(ack_o) |-> $past(take))
		else $error("answer without request");
	err_map_a: assert property (take && adr_i[15:14] != 2'b00 |=> err_o && !ack_o)
		else $error("unmapped access not refused");
	dat_quiet_a: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data outside answer");
	gap_write_a: assert property (
		take && we_i && adr_i == {2'b00, `PPC_IDX_GEN, 2'b00} |->
		##2 ipg_cycles_o == ($past(dat_i[3], 2) ? 4'h3 : 4'h5))
		else $error("gap does not follow write");
	gap_legal_a: assert property (!$past(rst_i) |-> ipg_cycles_o inside {4'h3, 4'h5})
		else $error("gap value illegal");
	deep_entry_a: assert property ($rose(deep_pwdn_o) |-> $past(std_pwdn_i, 2))
		else $error("deep entry without standard power-down");
	exit_len_a: assert property (run_q <= EXIT_SLOW_CYC + 24'd2)
		else $error("exit too long");
	idle_quiet_a: assert property (!idle_test_o [*3] |-> !idle_bit_o)
		else $error("pattern outside test mode");
	idle_single_a: assert property (idle_bit_o |=> !idle_bit_o)
		else $error("pattern one not followed by zero");
endmodule
bind ppc_regs ppc_regs_checker #(.EXIT_FAST_CYC(EXIT_FAST_CYC), .EXIT_SLOW_CYC(EXIT_SLOW_CYC))
	u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
	.std_pwdn_i(std_pwdn_i), .deep_pwdn_o(deep_pwdn_o), .pwdn_exiting_o(pwdn_exiting_o),
	.idle_test_o(idle_test_o), .idle_bit_o(idle_bit_o), .ipg_cycles_o(ipg_cycles_o));

// >>> dv/phy_power_test_config_regs_test.sv
// Purpose: Self-checking bench for the register bank
// Assumes: Answer one cycle after a request is taken
// Notes:   Exit lengths shortened to 20 and 40
`timescale 1ns/1ps
`include "ppc_map.vh"
module phy_power_test_config_regs_test;
	localparam int FAST = 20;
	localparam int SLOW = 40;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ana_det_i, std_pwdn_i, ack_o, err_o, ce_i;
	logic        ana_3v3_o, deep_pwdn_o, pwdn_exiting_o, idle_test_o, idle_bit_o, eq_cal_bypass_o;
	logic [15:0] adr_i, r;
	logic [31:0] dat_i, dat_o;
	logic [1:0]  io_det_i, io_level_o;
	logic [3:0]  idle_low_i, ipg_cycles_o;
	logic [17:0] q_exp[$];
	logic [17:0] e;
	int          failures = 0, n_tests = 0, c;
	ppc_regs #(.EXIT_FAST_CYC(24'd20), .EXIT_SLOW_CYC(24'd40)) DUT (.clk_i(clk_i),
		.rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(4'h3), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
		.ana_det_i(ana_det_i), .io_det_i(io_det_i), .std_pwdn_i(std_pwdn_i),
		.idle_low_i(idle_low_i), .ana_3v3_o(ana_3v3_o), .io_level_o(io_level_o),
		.deep_pwdn_o(deep_pwdn_o), .pwdn_exiting_o(pwdn_exiting_o), .idle_test_o(idle_test_o),
		.idle_bit_o(idle_bit_o), .eq_cal_bypass_o(eq_cal_bypass_o), .ipg_cycles_o(ipg_cycles_o));
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	function automatic logic [15:0] lf(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic ck(input logic [16:0] g, input logic [16:0] x);
		n_tests++;
		if (g !== x) begin
			failures++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	// Notes {check data, error, data}; the monitor settles it
	task automatic acc(input logic w, input logic [15:0] a, d, input logic [17:0] x);
		int k;
		k = 0;
		q_exp.push_back(x);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 16'h0000, d};
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && err_o !== 1'b1 && k < 20);
		{cyc_i, stb_i} <= 2'b00;
		if (k >= 20) failures++;
	endtask
	task automatic settle();
		repeat (3) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [11:0] i, input logic [15:0] d);
		acc(1'b1, {2'b00, i, 2'b00}, d, 18'h0);
		settle();
	endtask
	task automatic rd(input logic [11:0] i, input logic [15:0] x);
		acc(1'b0, {2'b00, i, 2'b00}, 16'h0000, {2'b10, x});
	endtask
	task automatic pins(input logic a, input logic [1:0] io, input logic s, input logic [3:0] l);
		@(posedge clk_i);
		{ana_det_i, io_det_i, std_pwdn_i, idle_low_i} <= {a, io, s, l};
		settle();
	endtask
	// Counts high cycles of the exit flag or the pattern over n cycles
	task automatic cnt(input int n, input bit x, output int k);
		k = 0;
		repeat (n) begin
			@(posedge clk_i);
			#1;
			k += x ? pwdn_exiting_o : idle_bit_o;
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 || err_o === 1'b1) begin
			e = q_exp.pop_front();
			ck({err_o, e[17] ? dat_o[15:0] : 16'h0000}, e[16:0]);
		end
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		complete_run();
	end
	initial begin
		{rst_i, cyc_i, stb_i, we_i, adr_i, dat_i, ana_det_i, io_det_i} = {4'h8, 51'h0};
		ce_i = 1'b1;
		{std_pwdn_i, idle_low_i, r} = {5'h0, 16'd38857};
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`PPC_IDX_AEQ, 16'h0000);
		rd(`PPC_IDX_SUPPLY, 16'h0000);
		rd(`PPC_IDX_DSP6, 16'h0141);
		rd(`PPC_IDX_GEN, 16'h0008);
		repeat (4) begin
			r = lf(r);
			wr(`PPC_IDX_AEQ, r & 16'h3F00);
			rd(`PPC_IDX_AEQ, r & 16'h3F00);
			wr(`PPC_IDX_DPD, r & 16'h003C);
			rd(`PPC_IDX_DPD, r & 16'h003C);
		end
		wr(`PPC_IDX_DPD, 16'h0000);
		acc(1'b0, 16'h1FFC, 16'h0000, 18'h10000);
		acc(1'b1, 16'h9158, 16'h0000, 18'h10000);
		rd(`PPC_IDX_GEN, 16'h0008);
		$display("reset and bus test done");
		wr(`PPC_IDX_GEN, 16'h0000);
		ck(17'(ipg_cycles_o), 17'h5);
		wr(`PPC_IDX_GEN, 16'h0008);
		ck(17'(ipg_cycles_o), 17'h3);
		pins(1'b0, 2'b01, 1'b0, 4'h2);
		wr(`PPC_IDX_SUPPLY, 16'h0000);
		ck(17'({ana_3v3_o, io_level_o}), 17'h1);
		wr(`PPC_IDX_SUPPLY, 16'h1C00);
		ck(17'({ana_3v3_o, io_level_o}), 17'h7);
		pins(1'b1, 2'b01, 1'b0, 4'h2);
		wr(`PPC_IDX_SUPPLY, 16'h0000);
		rd(`PPC_IDX_LEVEL, 16'h0005);
		wr(`PPC_IDX_DSP6, 16'h2141);
		ck(17'(eq_cal_bypass_o), 17'h1);
		wr(`PPC_IDX_DSP6, 16'h0141);
		ck(17'(eq_cal_bypass_o), 17'h0);
		$display("config test done");
		wr(`PPC_IDX_DPD, 16'h0010);
		cnt(9, 0, c);
		ck(17'(c), 17'h3);
		rd(`PPC_IDX_STAT, 16'h0001);
		pins(1'b1, 2'b01, 1'b0, 4'h0);
		cnt(9, 0, c);
		ck(17'(c), 17'h0);
		pins(1'b1, 2'b01, 1'b0, 4'hF);
		wr(`PPC_IDX_DPD, 16'h0030);
		cnt(64, 0, c);
		ck(17'(c), 17'h2);
		wr(`PPC_IDX_DPD, 16'h0004);
		cnt(9, 0, c);
		ck(17'({c[3:0], deep_pwdn_o}), 17'h0);
		$display("idle pattern test done");
		pins(1'b1, 2'b01, 1'b1, 4'hF);
		ck(17'(deep_pwdn_o), 17'h1);
		rd(`PPC_IDX_STAT, 16'h000A);
		acc(1'b1, {2'b00, `PPC_IDX_DPD, 2'b00}, 16'h0000, 18'h0);
		cnt(SLOW + 20, 1, c);
		ck(17'(c), 17'(SLOW));
		wr(`PPC_IDX_DPD, 16'h000C);
		ck(17'(deep_pwdn_o), 17'h1);
		acc(1'b1, {2'b00, `PPC_IDX_DPD, 2'b00}, 16'h0008, 18'h0);
		// Clock enable low must hold the exit timer and its flags still
		ce_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		ce_i <= 1'b1;
		ck(17'({deep_pwdn_o, pwdn_exiting_o}), 17'h2);
		cnt(SLOW + 20, 1, c);
		ck(17'(c), 17'(FAST));
		$display("deep power-down test done");
		complete_run();
	end
endmodule
